/* File: fcsm_defines.vh */
// Behaviour
// R1 - Only recognised command sequences start operations; any wrong cycle returns to array read.
// R2 - Command and read addresses are captured on the rising edge of address_valid_strobe_n.
// R3 - Command write data is captured on the rising edge of the write strobe.
// R4 - After power-up the device is in array read, no command needed.
// R5 - A bank returns to array read when its embedded program or erase completes.
// R6 - Erase suspend puts the bank in erase-suspend-read; other sectors stay readable.
// R7 - Program finishing during erase suspend restores reads, suspended sector still excluded.
// R8 - Program suspend puts the bank in program-suspend-read; other sectors readable.
// R9 - Host writes reset after timeout flag or autoselect to return bank to read.
// R10 - Configuration register holds wait states, burst mode, ready setup, synchronous enable.
// R11 - Configuration loads by two unlocks, D0h at 555h, then code at 000h.
// R12 - Host issues software reset after loading the configuration register.
// R13 - Power-up and hardware reset load the default, asynchronous configuration.
// R14 - Configuration is not changed while program, erase or sector lock runs.
// R15 - Query 40h-42h return P, R, I; 43h-44h return ASCII version digits.
// R16 - Query 45h returns 0020h: unlock required, silicon revision in bits 7-2.
// R17 - Query 46h returns 0002h; 50h returns 0001h for program suspend.
// R18 - Query 4Bh returns 0001h; 4Ch and 51h return 0000h.
// R19 - Query 4Fh returns 0003h for top boot, 0002h for bottom boot.
// R20 - Query 57h reports four banks; 58h-5Bh report 0020h or 0023h sectors.
// R21 - Query 55h and 56h each return 0005h suspend latency exponents.
// R22 - Query 52h returns 0008h; 4Ah returns 0020h.
// R23 - Configuration unlocks use the common unlock pairs; a mismatch aborts to read.
`ifndef FCSM_DEFINES_VH
`define FCSM_DEFINES_VH
`define FCSM_UNLOCK1_ADDR   12'h555
`define FCSM_UNLOCK1_DATA   8'hAA
`define FCSM_UNLOCK2_ADDR   12'h2AA
`define FCSM_UNLOCK2_DATA   8'h55
`define FCSM_CMD_ADDR       12'h555
`define FCSM_CFG_ADDR       12'h000
`define FCSM_CMD_CFG_SET    8'hD0
`define FCSM_CMD_CFI        8'h98
`define FCSM_CMD_PROGRAM    8'hA0
`define FCSM_CMD_ERASE      8'h80
`define FCSM_CMD_SECTOR_ER  8'h30
`define FCSM_CMD_SUSPEND    8'hB0
`define FCSM_CMD_RESUME     8'h30
`define FCSM_CMD_RESET      8'hF0
`define FCSM_CFG_RESET      16'hBDC8
`define FCSM_CFG_SYNC_BIT   15
`define FCSM_CFI_ADDR       8'h55
`endif

/* File: fcsm_query_rom.v */
`timescale 1ns/100ps
`include "fcsm_defines.vh"
module fcsm_query_rom (
    input  wire        top_boot,
    input  wire [7:0]  query_addr,
    output reg  [15:0] query_data
);
    // Extended query table lookup; unlisted addresses read zero.
    always @* begin
        case (query_addr)
            8'h40: query_data = 16'h0050; // R15
            8'h41: query_data = 16'h0052; // R15
            8'h42: query_data = 16'h0049; // R15
            8'h43: query_data = 16'h0031; // R15
            8'h44: query_data = 16'h0034; // R15
            8'h45: query_data = 16'h0020; // R16
            8'h46: query_data = 16'h0002; // R17
            8'h47: query_data = 16'h0001;
            8'h48: query_data = 16'h0000;
            8'h49: query_data = 16'h0008;
            8'h4A: query_data = 16'h0020; // R22
            8'h4B: query_data = 16'h0001; // R18
            8'h4C: query_data = 16'h0000; // R18
            8'h4D: query_data = 16'h0085;
            8'h4E: query_data = 16'h0095;
            8'h4F: query_data = top_boot ? 16'h0003 : 16'h0002; // R19
            8'h50: query_data = 16'h0001; // R17
            8'h51: query_data = 16'h0000; // R18
            8'h52: query_data = 16'h0008; // R22
            8'h53: query_data = 16'h000E;
            8'h54: query_data = 16'h000E;
            8'h55: query_data = 16'h0005; // R21
            8'h56: query_data = 16'h0005; // R21
            8'h57: query_data = 16'h0004; // R20
            8'h58: query_data = top_boot ? 16'h0020 : 16'h0023; // R20
            8'h59: query_data = 16'h0020; // R20
            8'h5A: query_data = 16'h0020; // R20
            8'h5B: query_data = top_boot ? 16'h0023 : 16'h0020; // R20
            default: query_data = 16'h0000;
        endcase
    end
endmodule // fcsm_query_rom

/* File: fcsm_command_machine.v */
`timescale 1ns/100ps
`include "fcsm_defines.vh"
module fcsm_command_machine (
    input  wire        clk,
    input  wire        rst,
    input  wire        top_boot,
    input  wire        address_valid_strobe_n,
    input  wire        write_strobe_n,
    input  wire [21:0] bus_addr,
    input  wire [15:0] bus_data,
    input  wire        algo_done,
    input  wire        timeout_flag_bit,
    input  wire        lock_busy,
    output reg  [15:0] config_reg,
    output reg  [1:0]  busy_bank,
    output reg  [2:0]  bank_mode,
    output reg  [21:0] op_addr,
    output reg         program_start,
    output reg         erase_start,
    output reg  [21:0] susp_erase_addr,
    output reg         erase_suspended,
    output reg         query_mode,
    output reg  [15:0] query_data,
    output reg  [21:0] latched_addr,
    output wire        read_allowed
);
    // Sequence states.
    localparam [3:0] S_READ   = 4'd0;
    localparam [3:0] S_UNL1   = 4'd1;
    localparam [3:0] S_UNL2   = 4'd2;
    localparam [3:0] S_CFG    = 4'd3;
    localparam [3:0] S_PGM    = 4'd4;
    localparam [3:0] S_ER1    = 4'd5;
    localparam [3:0] S_ER2    = 4'd6;
    localparam [3:0] S_ER3    = 4'd7;
    localparam [3:0] S_ER4    = 4'd8;
    localparam [3:0] S_QUERY  = 4'd9;
    // Bank operating modes reported on bank_mode.
    localparam [2:0] M_READ    = 3'd0;
    localparam [2:0] M_PGM     = 3'd1;
    localparam [2:0] M_ERASE   = 3'd2;
    localparam [2:0] M_ESR     = 3'd3;
    localparam [2:0] M_PSR     = 3'd4;
    localparam [2:0] M_ESPGM   = 3'd5;
    localparam [2:0] M_TIMEOUT = 3'd6;

    reg        avd_d;
    reg        we_d;
    reg [3:0]  state;
    reg [3:0]  next_state;
    reg [2:0]  next_mode;
    wire       addr_latch;
    wire       data_latch;
    wire [11:0] low_addr;
    wire [7:0] cmd;
    wire [15:0] rom_data;
    wire       operating;
    wire       same_sector;

    assign addr_latch = address_valid_strobe_n & ~avd_d;
    assign data_latch = write_strobe_n & ~we_d;
    assign low_addr   = latched_addr[11:0];
    assign cmd        = bus_data[7:0];
    assign operating  = (bank_mode == M_PGM) || (bank_mode == M_ERASE) || (bank_mode == M_ESPGM);
    assign same_sector = (latched_addr[21:15] == op_addr[21:15]);

    // Reads are refused from a busy bank except outside the held sector while suspended.
    assign read_allowed = (latched_addr[21:20] != busy_bank) || (bank_mode == M_READ) ||
                          (((bank_mode == M_ESR) || (bank_mode == M_ESPGM)) &&
                           (latched_addr[21:15] != susp_erase_addr[21:15])) || // R6 R7
                          ((bank_mode == M_PSR) && !same_sector); // R8

    fcsm_query_rom u_rom (
        .top_boot   (top_boot),
        .query_addr (latched_addr[7:0]),
        .query_data (rom_data)
    );

    // Strobe edge detection and address capture.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            avd_d        <= 1'b1;
            we_d         <= 1'b1;
            latched_addr <= 22'h000000;
            query_data   <= 16'h0000;
        end else begin
            avd_d <= address_valid_strobe_n;
            we_d  <= write_strobe_n;
            if (addr_latch) begin
                latched_addr <= bus_addr; // R2
            end
            query_data <= query_mode ? rom_data : 16'h0000; // R15
        end
    end

    // Next-state decode of the command sequence; data cycles only count on the write strobe.
    always @* begin
        next_state = state;
        next_mode  = bank_mode;
        if (algo_done && (bank_mode == M_PGM || bank_mode == M_ERASE)) begin
            next_mode = M_READ; // R5
        end else if (algo_done && bank_mode == M_ESPGM) begin
            next_mode = M_ESR; // R7
        end else if (timeout_flag_bit && operating) begin
            next_mode = M_TIMEOUT;
        end
        if (data_latch) begin
            // Fourth-cycle configuration codes and program data are taken whole, even when they look like reset.
            if (cmd == `FCSM_CMD_RESET && state != S_CFG && state != S_PGM) begin
                next_state = S_READ; // R9
                if (bank_mode == M_TIMEOUT) begin
                    next_mode = erase_suspended ? M_ESR : M_READ;
                end
            end else begin
                case (state)
                    S_READ, S_QUERY: begin
                        if (low_addr == `FCSM_UNLOCK1_ADDR && cmd == `FCSM_UNLOCK1_DATA) begin
                            next_state = S_UNL1;
                        end else if (cmd == `FCSM_CMD_CFI && low_addr[7:0] == `FCSM_CFI_ADDR) begin
                            next_state = S_QUERY;
                        end else if (cmd == `FCSM_CMD_SUSPEND && bank_mode == M_ERASE) begin
                            next_mode = M_ESR; // R6
                        end else if (cmd == `FCSM_CMD_SUSPEND && bank_mode == M_PGM) begin
                            next_mode = M_PSR; // R8
                        end else if (cmd == `FCSM_CMD_RESUME && bank_mode == M_ESR) begin
                            next_mode = M_ERASE;
                        end else if (cmd == `FCSM_CMD_RESUME && bank_mode == M_PSR) begin
                            next_mode = erase_suspended ? M_ESPGM : M_PGM;
                        end else begin
                            next_state = S_READ; // R1
                        end
                    end
                    S_UNL1: begin
                        if (low_addr == `FCSM_UNLOCK2_ADDR && cmd == `FCSM_UNLOCK2_DATA) begin
                            next_state = S_UNL2; // R23
                        end else begin
                            next_state = S_READ; // R23
                        end
                    end
                    S_UNL2: begin
                        if (low_addr != `FCSM_CMD_ADDR) begin
                            next_state = S_READ; // R1
                        end else if (cmd == `FCSM_CMD_CFG_SET) begin
                            next_state = S_CFG; // R11
                        end else if (cmd == `FCSM_CMD_PROGRAM &&
                                     (bank_mode == M_READ || bank_mode == M_ESR)) begin
                            next_state = S_PGM;
                        end else if (cmd == `FCSM_CMD_ERASE && bank_mode == M_READ) begin
                            next_state = S_ER1;
                        end else begin
                            next_state = S_READ; // R1
                        end
                    end
                    S_CFG: begin
                        next_state = S_READ;
                    end
                    S_PGM: begin
                        next_state = S_READ;
                        next_mode  = (bank_mode == M_ESR) ? M_ESPGM : M_PGM;
                    end
                    S_ER1: begin
                        next_state = (low_addr == `FCSM_UNLOCK1_ADDR && cmd == `FCSM_UNLOCK1_DATA) ?
                                     S_ER2 : S_READ; // R1
                    end
                    S_ER2: begin
                        next_state = (low_addr == `FCSM_UNLOCK2_ADDR && cmd == `FCSM_UNLOCK2_DATA) ?
                                     S_ER3 : S_READ; // R1
                    end
                    S_ER3: begin
                        next_state = S_READ;
                        if (cmd == `FCSM_CMD_SECTOR_ER) begin
                            next_mode = M_ERASE;
                        end
                    end
                    default: begin
                        next_state = S_READ;
                    end
                endcase
            end
        end
    end

    // Sequence state, bank mode, configuration and operation launch.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state           <= S_READ; // R4
            bank_mode       <= M_READ; // R4
            config_reg      <= `FCSM_CFG_RESET; // R13
            busy_bank       <= 2'b00;
            op_addr         <= 22'h000000;
            susp_erase_addr <= 22'h000000;
            erase_suspended <= 1'b0;
            query_mode      <= 1'b0;
            program_start   <= 1'b0;
            erase_start     <= 1'b0;
        end else begin
            state         <= next_state;
            bank_mode     <= next_mode;
            query_mode    <= (next_state == S_QUERY);
            program_start <= 1'b0;
            erase_start   <= 1'b0;
            if (data_latch && state == S_CFG && low_addr == `FCSM_CFG_ADDR &&
                !operating && !lock_busy) begin
                config_reg <= bus_data; // R3 R10 R11 R14
            end
            if (data_latch && state == S_PGM) begin
                op_addr       <= latched_addr; // R3
                busy_bank     <= latched_addr[21:20];
                program_start <= 1'b1;
            end
            if (data_latch && state == S_ER3 && cmd == `FCSM_CMD_SECTOR_ER) begin
                op_addr     <= latched_addr;
                busy_bank   <= latched_addr[21:20];
                erase_start <= 1'b1;
            end
            if (next_mode == M_ESR && bank_mode == M_ERASE) begin
                susp_erase_addr <= op_addr; // R6
                erase_suspended <= 1'b1;
            end else if (next_mode == M_ERASE || next_mode == M_READ) begin
                erase_suspended <= 1'b0;
            end
        end
    end
endmodule // fcsm_command_machine

/* File: fcsm_host_model.sv */
`timescale 1ns/100ps
module fcsm_host_model (
    input  wire        clk,
    output reg         address_valid_strobe_n,
    output reg         write_strobe_n,
    output reg  [21:0] bus_addr,
    output reg  [15:0] bus_data
);
    // The bus starts idle with both strobes high.
    initial begin
        address_valid_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        bus_addr = 22'h000000;
        bus_data = 16'h0000;
    end
    // One host cycle: address strobe, then the optional write strobe, each low for two clocks, then high for two and three clocks.
    task cyc(input [21:0] a, input [15:0] d, input wr);
        begin
            @(negedge clk);
            bus_addr = a;
            address_valid_strobe_n = 1'b0;
            repeat (2) @(negedge clk);
            address_valid_strobe_n = 1'b1;
            repeat (2) @(negedge clk);
            bus_data = d;
            write_strobe_n = !wr;
            repeat (2) @(negedge clk);
            write_strobe_n = 1'b1;
            repeat (3) @(negedge clk);
            bus_addr = ~a; // A released bus no longer shows the last value.
            bus_data = ~d;
        end
    endtask
endmodule // fcsm_host_model

/* File: fcsm_checker_sva.sv */
`timescale 1ns/100ps
module fcsm_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        address_valid_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic [21:0] bus_addr,
    input wire logic [15:0] bus_data,
    input wire logic        algo_done,
    input wire logic        lock_busy,
    input wire logic [15:0] config_reg,
    input wire logic [2:0]  bank_mode,
    input wire logic        program_start,
    input wire logic        erase_start,
    input wire logic        erase_suspended,
    input wire logic [21:0] latched_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Address strobe rising edge and the program (mode 1), erase (mode 2) and sector lock states that lock the configuration.
    sequence s_addr_rise;
        !address_valid_strobe_n ##1 address_valid_strobe_n;
    endsequence
    sequence s_busy;
        (bank_mode == 3'h1) || (bank_mode == 3'h2) || lock_busy;
    endsequence
    // Outputs tied to their causes at the inputs.
    AST_RESET_CFG: assert property ($fell(rst) |-> config_reg == 16'hBDC8 && bank_mode == 3'h0)
        else $error("reset state wrong");
    AST_ADDR_LATCH: assert property (s_addr_rise |-> ##[1:2] latched_addr == bus_addr)
        else $error("address not latched");
    AST_CFG_DATA: assert property ($changed(config_reg) && !$past(rst) |-> config_reg == bus_data && write_strobe_n)
        else $error("configuration not from write data");
    AST_CFG_HOLD: assert property (s_busy |=> $stable(config_reg))
        else $error("configuration changed while busy");
    AST_PROG_PULSE: assert property ($rose(program_start) |=> !program_start)
        else $error("program start too long");
    AST_ERASE_PULSE: assert property (erase_start |=> !erase_start)
        else $error("erase start too long");
    AST_DONE_READ: assert property (algo_done && (bank_mode == 3'h1 || bank_mode == 3'h2) |-> ##[1:2] bank_mode == 3'h0)
        else $error("no return to read");
    AST_SUSP_FLAG: assert property (bank_mode == 3'h3 |-> erase_suspended)
        else $error("suspend flag missing");
    AST_SUSP_PROG_DONE: assert property (algo_done && bank_mode == 3'h5 |-> ##[1:2] bank_mode == 3'h3)
        else $error("no return to suspend read");
endmodule // fcsm_checker
bind fcsm_command_machine fcsm_checker u_fcsm_checker (
    .clk(clk), .rst(rst), .address_valid_strobe_n(address_valid_strobe_n), .write_strobe_n(write_strobe_n),
    .bus_addr(bus_addr), .bus_data(bus_data), .algo_done(algo_done), .lock_busy(lock_busy),
    .config_reg(config_reg), .bank_mode(bank_mode), .program_start(program_start), .erase_start(erase_start),
    .erase_suspended(erase_suspended), .latched_addr(latched_addr)
);

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench;
    localparam [223:0] QTAB = {8'h50, 8'h52, 8'h49, 8'h31, 8'h34, 8'h20, 8'h02, 8'h01, 8'h00, 8'h08, 8'h20, 8'h01,
        8'h00, 8'h85, 8'h95, 8'h03, 8'h01, 8'h00, 8'h08, 8'h0E, 8'h0E, 8'h05, 8'h05, 8'h04, 8'h20, 8'h20, 8'h20, 8'h23};
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         top_boot = 1'b0;
    reg         algo_done = 1'b0;
    reg         timeout_flag_bit = 1'b0;
    reg         lock_busy = 1'b0;
    reg  [21:0] n_prog = 22'h000000;
    reg  [21:0] n_erase = 22'h000000;
    reg  [7:0]  q;
    wire        address_valid_strobe_n, write_strobe_n, program_start, erase_start, erase_suspended, query_mode;
    wire [21:0] bus_addr, susp_erase_addr, latched_addr, op_addr;
    wire [1:0]  busy_bank;
    wire        read_allowed;
    wire [15:0] bus_data, config_reg, query_data;
    wire [2:0]  bank_mode;
    integer     miscompares = 0, total_checks = 0, cycles = 0, i;
    always #25 clk = ~clk;
    fcsm_host_model u_fcsm_host_model (.clk(clk), .address_valid_strobe_n(address_valid_strobe_n),
        .write_strobe_n(write_strobe_n), .bus_addr(bus_addr), .bus_data(bus_data));
    fcsm_command_machine u_fcsm_command_machine (.clk(clk), .rst(rst), .top_boot(top_boot),
        .address_valid_strobe_n(address_valid_strobe_n), .write_strobe_n(write_strobe_n), .bus_addr(bus_addr),
        .bus_data(bus_data), .algo_done(algo_done), .timeout_flag_bit(timeout_flag_bit), .lock_busy(lock_busy),
        .config_reg(config_reg), .busy_bank(busy_bank), .bank_mode(bank_mode), .op_addr(op_addr),
        .program_start(program_start),
        .erase_start(erase_start), .susp_erase_addr(susp_erase_addr), .erase_suspended(erase_suspended),
        .query_mode(query_mode), .query_data(query_data), .latched_addr(latched_addr),
        .read_allowed(read_allowed));
    // Count start pulses and cut a hung run short.
    always @(posedge clk) begin
        cycles = cycles + 1;
        n_prog = n_prog + {21'h0, program_start === 1'b1};
        n_erase = n_erase + {21'h0, erase_start === 1'b1};
        if (cycles == 4000) begin
            miscompares = miscompares + 1;
            close_out;
        end
    end
    task close_out;
        begin
            if (miscompares == 0 && total_checks > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    task chk(input [21:0] got, input [21:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("Error t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [21:0] a, input [15:0] d);
        u_fcsm_host_model.cyc(a, d, 1'b1);
    endtask
    task unl;
        begin
            wr(22'h000555, 16'h00AA);
            wr(22'h0002AA, 16'h0055);
        end
    endtask
    task done_pulse;
        begin
            algo_done = 1'b1;
            @(negedge clk);
            algo_done = 1'b0;
            @(negedge clk);
        end
    endtask
    // Expected query word; the boot variant moves three entries.
    function [21:0] qexp(input [7:0] a, input top);
        reg [7:0] v;
        begin
            v = QTAB[(8'h5B - a) * 8 +: 8];
            if (!top && a == 8'h4F) v = 8'h02;
            if (!top && a == 8'h58) v = 8'h23;
            if (!top && a == 8'h5B) v = 8'h20;
            qexp = {14'h0000, v};
        end
    endfunction
    // Reset, configuration, query table, then program, erase and timeout flows.
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        chk({6'h00, config_reg}, 22'h00BDC8);
        chk({19'h0, bank_mode}, 22'h0);
        unl;
        wr(22'h000555, 16'h00D0);
        wr(22'h000000, 16'h1234);
        chk({6'h00, config_reg}, 22'h001234);
        wr(22'h000000, 16'h00F0);
        wr(22'h000555, 16'h00AA);
        wr(22'h0002AA, 16'h0056);
        wr(22'h000555, 16'h00D0);
        wr(22'h000000, 16'h5678);
        chk({6'h00, config_reg}, 22'h001234);
        lock_busy = 1'b1;
        unl;
        wr(22'h000555, 16'h00D0);
        wr(22'h000000, 16'h0042);
        lock_busy = 1'b0;
        chk({6'h00, config_reg}, 22'h001234);
        for (i = 0; i < 2; i = i + 1) begin
            top_boot = i[0];
            wr(22'h000055, 16'h0098);
            chk({21'h0, query_mode}, 22'h1);
            for (q = 8'h40; q <= 8'h5B; q = q + 8'h01) begin
                u_fcsm_host_model.cyc({14'h0000, q}, 16'h0000, 1'b0);
                chk({6'h00, query_data}, qexp(q, i[0]));
            end
            chk(latched_addr, 22'h00005B);
            wr(22'h000000, 16'h00F0);
            chk({21'h0, query_mode}, 22'h0);
            chk({6'h00, query_data}, 22'h0);
        end
        unl;
        wr(22'h000555, 16'h00A0);
        wr(22'h100010, 16'hBEEF);
        chk({19'h0, bank_mode}, 22'h1);
        chk(n_prog, 22'h000001);
        chk(op_addr, 22'h100010);
        chk({20'h0, busy_bank}, 22'h1);
        wr(22'h100010, 16'h00B0);
        chk({19'h0, bank_mode}, 22'h4);
        chk({21'h0, read_allowed}, 22'h0);
        u_fcsm_host_model.cyc(22'h108000, 16'h0000, 1'b0);
        chk({21'h0, read_allowed}, 22'h1);
        wr(22'h100010, 16'h0030);
        chk({19'h0, bank_mode}, 22'h1);
        done_pulse;
        chk({19'h0, bank_mode}, 22'h0);
        unl;
        wr(22'h000555, 16'h0080);
        unl;
        wr(22'h208000, 16'h0030);
        chk({19'h0, bank_mode}, 22'h2);
        chk(n_erase, 22'h000001);
        wr(22'h208000, 16'h00B0);
        chk({19'h0, bank_mode}, 22'h3);
        chk(susp_erase_addr, 22'h208000);
        chk({21'h0, read_allowed}, 22'h0);
        u_fcsm_host_model.cyc(22'h218000, 16'h0000, 1'b0);
        chk({21'h0, read_allowed}, 22'h1);
        unl;
        wr(22'h000555, 16'h00A0);
        wr(22'h210000, 16'h1111);
        chk({19'h0, bank_mode}, 22'h5);
        done_pulse;
        chk({19'h0, bank_mode}, 22'h3);
        u_fcsm_host_model.cyc(22'h208000, 16'h0000, 1'b0);
        chk({21'h0, read_allowed}, 22'h0);
        u_fcsm_host_model.cyc(22'h210000, 16'h0000, 1'b0);
        chk({21'h0, read_allowed}, 22'h1);
        wr(22'h208000, 16'h0030);
        done_pulse;
        chk({19'h0, bank_mode}, 22'h0);
        unl;
        wr(22'h000555, 16'h00A0);
        wr(22'h100020, 16'h2222);
        timeout_flag_bit = 1'b1;
        repeat (2) @(negedge clk);
        chk({19'h0, bank_mode}, 22'h6);
        timeout_flag_bit = 1'b0;
        wr(22'h100020, 16'h00F0);
        chk({19'h0, bank_mode}, 22'h0);
        // A code whose low byte matches reset is still stored, then a mid-run reset restores the default.
        unl;
        wr(22'h000555, 16'h00D0);
        wr(22'h000000, 16'h43F0);
        chk({6'h00, config_reg}, 22'h0043F0);
        wr(22'h000000, 16'h00F0);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk({6'h00, config_reg}, 22'h00BDC8);
        chk({19'h0, bank_mode}, 22'h0);
        close_out;
    end
endmodule // testbench
